// [usb_rst_pkg.sv]
// Constants, register map and carrier structs of the reset/wakeup block.
// Assumes a 250 MHz system clock and an Avalon-MM register slave.
//
// Summary of operation
// - Resume K-state only after 5ms bus idle
// - Set remote wakeup done flag after resume
// - D+ fall in power-down restarts oscillator
// - Soft chip reset acts like reset pin
// - Power-on and chip reset clear host mode
// - Power-on clears all, sets three buffer-free flags
// - Chip reset keeps soft reset bit; master clears
// - Chip reset keeps connect, outputs, aux select
// - Chip reset keeps interface and wake bits
// - Chip reset sets buffer-free flags, clears other flags and enables
// - Peripheral SE0 21.33us sets bus reset flag
// - Bus reset keeps chip-reset set plus more
// - Endpoint buffer data never cleared
// - Bus reset clears most flags and enables
// - Host bus reset request, bus event on end
// - VBUS rise and fall raise separate flags
// - Wakeup request: osc start, 10ms K-state
// - Oscillator stable flag after restart settles
// - Power-down stops osc; watch D+ and bus
package usb_rst_pkg;
  localparam int unsigned CLK_HZ        = 250000000;
  localparam int unsigned IDLE_US       = 5000;   // Bus idle before resume
  localparam int unsigned RESUME_US     = 10000;  // Resume K-state length
  localparam int unsigned HOST_RST_US   = 50000;  // Host bus reset drive
  localparam int unsigned OSC_SETTLE_US = 1000;   // Oscillator settle time
  localparam int unsigned SE0_NS        = 21330;  // SE0 reset detect
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1000000;
  localparam int unsigned IDLE_CYC      = IDLE_US * CYC_PER_US;
  localparam int unsigned RESUME_CYC    = RESUME_US * CYC_PER_US;
  localparam int unsigned HOST_RST_CYC  = HOST_RST_US * CYC_PER_US;
  localparam int unsigned OSC_CYC       = OSC_SETTLE_US * CYC_PER_US;
  // Least time: round up
  localparam int unsigned SE0_CYC       = (SE0_NS * 25 + 99) / 100;

  // Register byte addresses
  localparam logic [3:0] ADDR_USB_EVENT  = 4'h0;
  localparam logic [3:0] ADDR_USB_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_USB_CTRL   = 4'h8;
  localparam logic [3:0] ADDR_PIN_CTRL   = 4'hc;

  // Event register bit positions
  localparam int unsigned EV_RWU_DONE = 0;
  localparam int unsigned EV_BUS_RST  = 1;
  localparam int unsigned EV_RST_DONE = 2;
  localparam int unsigned EV_OSC_OK   = 3;
  localparam int unsigned EV_VBUS_ON  = 4;
  localparam int unsigned EV_VBUS_OFF = 5;
  localparam int unsigned EV_BUS_EVT  = 6;
  localparam int unsigned EV_IN0_FREE = 7;
  localparam int unsigned EV_IN2_FREE = 8;
  localparam int unsigned EV_IN3_FREE = 9;
  localparam int unsigned EV_W        = 10;
  // Flags that survive a bus reset
  localparam logic [9:0] EV_BUS_RESET_REQUEST_KEEP = 10'h006;
  // Power-on value: three IN buffer-free flags set
  localparam logic [9:0] EV_POR_VAL     = 10'h380;

  // Control register bit positions
  localparam int unsigned CT_SOFT_RST  = 0;
  localparam int unsigned CT_CONNECT   = 1;
  localparam int unsigned CT_HOST_WAKE = 2;
  localparam int unsigned CT_PWR_DOWN  = 3;
  localparam int unsigned CT_RWU_REQ   = 4;
  localparam int unsigned CT_HOST_MODE = 5;
  localparam int unsigned CT_BUS_RST   = 6;
  localparam int unsigned CT_GLOBAL_IE = 7;

  // Pin control fields
  localparam int unsigned PC_GPO_LSB = 0;
  localparam int unsigned PC_AUX_LO  = 8;
  localparam int unsigned PC_AUX_HI  = 9;
  localparam int unsigned PC_FDUP    = 10;
  localparam int unsigned PC_LEVEL   = 11;
  localparam int unsigned PC_POL     = 12;
  localparam int unsigned PC_W       = 13;

  typedef struct packed {
    logic [EV_W-1:0] flags;   // Sticky event flags
    logic [EV_W-1:0] enable;  // Per-flag enables
    logic [7:0]      ctrl;    // Control bits
    logic [PC_W-1:0] pins;    // Interface and pin bits
  } regs_s;

  typedef struct packed {
    logic dp;     // D+ level
    logic dm;     // D- level
    logic vbus;   // VBUS sense input
  } line_s;
endpackage

// [usb_tick_timer.sv]
// Down counter timing the bus intervals of the sequencer.
// Assumes a load pulse starts it; done is a one-cycle pulse.
`timescale 1ns/1ps
module usb_tick_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  initial begin
    if (W < 2 || W > 31) $error("usb_tick_timer width out of range");
  end

  logic [W-1:0] cnt;       // Remaining cycles
  logic [W-1:0] next_cnt;
  logic         next_done;

  // Next count; load restarts even when running
  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = count;
    end else if (cnt != '0) begin
      next_cnt  = cnt - W'(1);
      next_done = (cnt == W'(1));
    end
  end

  // Register only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  assign busy = (cnt != '0);
endmodule

// [usb_reset_wakeup_control.sv]
// Reset levels, remote wakeup, host bus reset and VBUS edge flags.
// Assumes synchronous bus line inputs and an Avalon-MM master.
`timescale 1ns/1ps
module usb_reset_wakeup_control #(
  parameter int unsigned IDLE_CYC     = usb_rst_pkg::IDLE_CYC,
  parameter int unsigned RESUME_CYC   = usb_rst_pkg::RESUME_CYC,
  parameter int unsigned HOST_RST_CYC = usb_rst_pkg::HOST_RST_CYC,
  parameter int unsigned OSC_CYC      = usb_rst_pkg::OSC_CYC,
  parameter int unsigned SE0_CYC      = usb_rst_pkg::SE0_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        hardware_reset_pin_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dp,
  input  wire logic        dm,
  input  wire logic        vbus_sense_input,
  input  wire logic        bus_activity,
  output logic             drive_k_state,
  output logic             drive_se0,
  output logic             osc_run,
  output logic             pullup_on,
  output logic [7:0]       general_outputs,
  output logic             irq_pending
);
  localparam int unsigned TW = 24;
  initial begin
    if (IDLE_CYC < 1 || RESUME_CYC < 1 || HOST_RST_CYC < 1 || OSC_CYC < 1
        || SE0_CYC < 1 || HOST_RST_CYC >= (1 << TW)
        || RESUME_CYC >= (1 << TW) || IDLE_CYC >= (1 << TW)
        || OSC_CYC >= (1 << TW) || SE0_CYC >= (1 << TW))
      $error("usb_reset_wakeup_control timing parameter out of range");
  end

  // Reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  typedef enum {
    ST_IDLE, ST_OSC_WAIT, ST_IDLE_WAIT, ST_RESUME, ST_HOST_RST
  } seq_e;

  usb_rst_pkg::regs_s regs;        // Software-visible registers
  usb_rst_pkg::regs_s next_regs;
  seq_e               state;       // Wakeup / bus reset sequencer
  seq_e               next_state;
  usb_rst_pkg::line_s line_q;      // Previous line sample
  usb_rst_pkg::line_s line_now;
  logic [TW-1:0]      se0_cnt;     // SE0 length counter
  logic [TW-1:0]      next_se0_cnt;
  logic [TW-1:0]      idle_cnt;    // Bus idle counter
  logic [TW-1:0]      next_idle_cnt;
  logic               in_reset;    // Bus reset seen, SE0 still on
  logic               next_in_reset;
  logic               osc_on;      // Oscillator running
  logic               next_osc_on;
  logic [31:0]        next_rdata;
  logic               tmr_load;    // Sequencer timer interface
  logic [TW-1:0]      tmr_count;
  logic               tmr_done;
  logic               chip_rst;    // Chip-level reset in effect
  logic               se0;
  logic               wr_ok;
  logic               rd_ok;
  logic               bus_rst_hit;

  assign line_now = '{dp: dp, dm: dm, vbus: vbus_sense_input};
  assign se0      = !dp && !dm;
  // Soft reset acts as the reset pin does
  assign chip_rst = !hardware_reset_pin_n
                    || regs.ctrl[usb_rst_pkg::CT_SOFT_RST];
  // Registers answer in one cycle: wait on the first cycle, free after
  logic acc_q;
  logic next_acc_q;
  assign next_acc_q = (avs_read || avs_write) && !acc_q;
  assign avs_waitrequest = (avs_read || avs_write) && !acc_q;
  assign wr_ok = avs_write && acc_q;
  assign rd_ok = avs_read && !acc_q;
  assign bus_rst_hit = !regs.ctrl[usb_rst_pkg::CT_HOST_MODE]
                       && se0 && (se0_cnt == TW'(SE0_CYC - 1));

  usb_tick_timer #(.W(TW)) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .count   (tmr_count),
    .busy    (),
    .done    (tmr_done)
  );

  // SE0 and idle measurement
  always_comb begin
    next_se0_cnt  = se0 ? se0_cnt : '0;
    if (se0 && se0_cnt != TW'(SE0_CYC))
      next_se0_cnt = se0_cnt + TW'(1);
    // Idle means no activity on the bus and no SE0
    next_idle_cnt = (bus_activity || se0) ? '0 : idle_cnt;
    if (!bus_activity && !se0 && idle_cnt != TW'(IDLE_CYC))
      next_idle_cnt = idle_cnt + TW'(1);
    next_in_reset = in_reset;
    if (bus_rst_hit)
      next_in_reset = 1'b1;
    else if (!se0)
      next_in_reset = 1'b0;
  end

  // Sequencer: wakeup resume and host bus reset
  always_comb begin
    next_state  = state;
    next_osc_on = osc_on;
    tmr_load    = 1'b0;
    tmr_count   = '0;
    if (regs.ctrl[usb_rst_pkg::CT_PWR_DOWN])
      next_osc_on = 1'b0;
    case (state)
      ST_IDLE: begin
        if (regs.ctrl[usb_rst_pkg::CT_RWU_REQ]
            && !regs.flags[usb_rst_pkg::EV_RWU_DONE]) begin
          // Restart oscillator first
          next_osc_on = 1'b1;
          tmr_load    = 1'b1;
          tmr_count   = TW'(OSC_CYC);
          next_state  = ST_OSC_WAIT;
        end else if (regs.ctrl[usb_rst_pkg::CT_HOST_MODE]
                     && regs.ctrl[usb_rst_pkg::CT_BUS_RST]) begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(HOST_RST_CYC);
          next_state = ST_HOST_RST;
        end else if (!osc_on && regs.ctrl[usb_rst_pkg::CT_PWR_DOWN]
                     && regs.ctrl[usb_rst_pkg::CT_HOST_WAKE]
                     && line_q.dp && !dp) begin
          // D+ falling edge wakes the oscillator
          tmr_load   = 1'b1;
          tmr_count  = TW'(OSC_CYC);
          next_state = ST_OSC_WAIT;
        end else if (!osc_on && !regs.ctrl[usb_rst_pkg::CT_PWR_DOWN]) begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(OSC_CYC);
          next_state = ST_OSC_WAIT;
        end
      end
      ST_OSC_WAIT: begin
        next_osc_on = 1'b1;
        if (tmr_done)
          next_state = regs.ctrl[usb_rst_pkg::CT_RWU_REQ]
                       ? ST_IDLE_WAIT : ST_IDLE;
      end
      ST_IDLE_WAIT: begin
        next_osc_on = 1'b1;
        if (idle_cnt == TW'(IDLE_CYC)) begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(RESUME_CYC);
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        next_osc_on = 1'b1;
        if (tmr_done)
          next_state = ST_IDLE;
      end
      ST_HOST_RST: begin
        if (tmr_done)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Register file: resets, events, bus writes
  always_comb begin
    logic [usb_rst_pkg::EV_W-1:0] set_ev;
    set_ev    = '0;
    next_regs = regs;
    // Hardware events
    set_ev[usb_rst_pkg::EV_RWU_DONE] = (state == ST_RESUME) && tmr_done;
    set_ev[usb_rst_pkg::EV_OSC_OK]   = (state == ST_OSC_WAIT)
                                       && tmr_done;
    set_ev[usb_rst_pkg::EV_BUS_EVT]  = (state == ST_HOST_RST)
                                       && tmr_done;
    set_ev[usb_rst_pkg::EV_BUS_RST]  = bus_rst_hit;
    set_ev[usb_rst_pkg::EV_RST_DONE] = in_reset && !se0;
    set_ev[usb_rst_pkg::EV_VBUS_ON]  = !line_q.vbus && vbus_sense_input;
    set_ev[usb_rst_pkg::EV_VBUS_OFF] = line_q.vbus && !vbus_sense_input;
    // Bus write; flags clear by writing one
    if (wr_ok) begin
      case (avs_address)
        usb_rst_pkg::ADDR_USB_EVENT:
          next_regs.flags = regs.flags
                            & ~avs_writedata[usb_rst_pkg::EV_W-1:0];
        usb_rst_pkg::ADDR_USB_ENABLE:
          next_regs.enable = avs_writedata[usb_rst_pkg::EV_W-1:0];
        usb_rst_pkg::ADDR_USB_CTRL:
          next_regs.ctrl = avs_writedata[7:0];
        usb_rst_pkg::ADDR_PIN_CTRL:
          next_regs.pins = avs_writedata[usb_rst_pkg::PC_W-1:0];
        default: ;
      endcase
    end
    // Host reset request self-clears when done
    if (set_ev[usb_rst_pkg::EV_BUS_EVT])
      next_regs.ctrl[usb_rst_pkg::CT_BUS_RST] = 1'b0;
    // Bus reset: clear flags and enables but the reset's own bits
    if (bus_rst_hit) begin
      next_regs.flags  = regs.flags & usb_rst_pkg::EV_BUS_RESET_REQUEST_KEEP;
      next_regs.enable = regs.enable & usb_rst_pkg::EV_BUS_RESET_REQUEST_KEEP;
      next_regs.ctrl[usb_rst_pkg::CT_BUS_RST] = 1'b0;
    end
    // Chip reset loads power-on flags and clears all else but the kept bits
    if (chip_rst) begin
      next_regs.flags  = usb_rst_pkg::EV_POR_VAL;
      next_regs.enable = '0;
      next_regs.ctrl[usb_rst_pkg::CT_HOST_MODE] = 1'b0;
      next_regs.ctrl[usb_rst_pkg::CT_BUS_RST]   = 1'b0;
      next_regs.ctrl[usb_rst_pkg::CT_GLOBAL_IE] = 1'b0;
      // Soft reset bit moves only by a bus write; master ends the reset
      if (!(wr_ok && avs_address == usb_rst_pkg::ADDR_USB_CTRL))
        next_regs.ctrl[usb_rst_pkg::CT_SOFT_RST] =
          regs.ctrl[usb_rst_pkg::CT_SOFT_RST];
      // Connect, wake bits and pins kept
      next_regs.ctrl[usb_rst_pkg::CT_CONNECT] =
        regs.ctrl[usb_rst_pkg::CT_CONNECT];
      next_regs.ctrl[usb_rst_pkg::CT_HOST_WAKE] =
        regs.ctrl[usb_rst_pkg::CT_HOST_WAKE];
      next_regs.ctrl[usb_rst_pkg::CT_PWR_DOWN] =
        regs.ctrl[usb_rst_pkg::CT_PWR_DOWN];
      next_regs.ctrl[usb_rst_pkg::CT_RWU_REQ] =
        regs.ctrl[usb_rst_pkg::CT_RWU_REQ];
      next_regs.pins = regs.pins;
    end
    // Set wins over clear, outside chip reset
    if (!chip_rst)
      next_regs.flags = next_regs.flags | set_ev;
    // Read data
    next_rdata = '0;
    if (rd_ok) begin
      case (avs_address)
        usb_rst_pkg::ADDR_USB_EVENT:  next_rdata = 32'(regs.flags);
        usb_rst_pkg::ADDR_USB_ENABLE: next_rdata = 32'(regs.enable);
        usb_rst_pkg::ADDR_USB_CTRL:   next_rdata = 32'(regs.ctrl);
        usb_rst_pkg::ADDR_PIN_CTRL:   next_rdata = 32'(regs.pins);
        default:                      next_rdata = '0;
      endcase
    end
  end

  // Register all state; power-on values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs         <= '{flags: usb_rst_pkg::EV_POR_VAL,
                        enable: '0, ctrl: '0, pins: '0};
      state        <= ST_IDLE;
      line_q       <= '0;
      se0_cnt      <= '0;
      idle_cnt     <= '0;
      in_reset     <= 1'b0;
      osc_on       <= 1'b1;
      acc_q        <= 1'b0;
      avs_readdata <= '0;
    end else begin
      regs         <= next_regs;
      state        <= next_state;
      line_q       <= line_now;
      se0_cnt      <= next_se0_cnt;
      idle_cnt     <= next_idle_cnt;
      in_reset     <= next_in_reset;
      osc_on       <= next_osc_on;
      acc_q        <= next_acc_q;
      // Read data stands through the answer cycle and the one after, then clears
      avs_readdata <= acc_q ? avs_readdata : next_rdata;
    end
  end

  // Endpoint buffer data lives elsewhere and is never cleared here.
  assign drive_k_state   = (state == ST_RESUME);
  assign drive_se0       = (state == ST_HOST_RST);
  assign osc_run         = osc_on;
  assign pullup_on       = regs.ctrl[usb_rst_pkg::CT_CONNECT];
  assign general_outputs = regs.pins[usb_rst_pkg::PC_GPO_LSB +: 8];
  // Interrupt request kept alive in power-down
  assign irq_pending     = regs.ctrl[usb_rst_pkg::CT_GLOBAL_IE]
                           && |(regs.flags & regs.enable);
endmodule

// [usb_rst_asserts.sv]
// Port-level checker for the reset and wakeup block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module usb_rst_asserts #(
  parameter int unsigned IDLE_CYC     = 20,
  parameter int unsigned RESUME_CYC   = 20,
  parameter int unsigned HOST_RST_CYC = 20
) (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        hardware_reset_pin_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        bus_activity,
  input wire logic        drive_k_state,
  input wire logic        drive_se0,
  input wire logic        osc_run,
  input wire logic        pullup_on,
  input wire logic [7:0]  general_outputs,
  input wire logic        irq_pending
);
  int unsigned idle_cnt;  // Quiet bus cycles
  int unsigned k_cnt;     // Resume drive cycles
  int unsigned s_cnt;     // Host SE0 drive cycles

  // Run lengths; each restarts when its cause drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= 0;
      k_cnt    <= 0;
      s_cnt    <= 0;
    end else begin
      idle_cnt <= bus_activity ? 0 : idle_cnt + 1;
      k_cnt    <= drive_k_state ? k_cnt + 1 : 0;
      s_cnt    <= drive_se0 ? s_cnt + 1 : 0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Request seen, answer still pending
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Accepted write of the soft reset bit
  sequence s_soft;
    avs_write && !avs_waitrequest &&
    avs_address == usb_rst_pkg::ADDR_USB_CTRL &&
    avs_writedata[usb_rst_pkg::CT_SOFT_RST];
  endsequence

  property p_answer;
    s_req |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("waitrequest not low one cycle after request");
  // Slack of one covers where the idle count starts
  property p_idle;
    $rose(drive_k_state) |-> idle_cnt >= IDLE_CYC - 1;
  endproperty
  a_idle: assert property (p_idle)
    else $error("resume started without enough bus idle");
  property p_k_len;
    $fell(drive_k_state) |-> k_cnt inside {[RESUME_CYC:RESUME_CYC+1]};
  endproperty
  a_k_len: assert property (p_k_len)
    else $error("resume drive length wrong");
  property p_k_osc;
    drive_k_state |-> osc_run;
  endproperty
  a_k_osc: assert property (p_k_osc)
    else $error("resume driven with oscillator stopped");
  property p_keep;
    !hardware_reset_pin_n && !avs_write |=>
      $stable(general_outputs) && $stable(pullup_on);
  endproperty
  a_keep: assert property (p_keep)
    else $error("chip reset changed outputs or connect");
  property p_pin_irq;
    !hardware_reset_pin_n |-> ##[1:3] !irq_pending;
  endproperty
  a_pin_irq: assert property (p_pin_irq)
    else $error("interrupt stayed up under chip reset");
  property p_soft_irq;
    s_soft |-> ##[1:3] !irq_pending;
  endproperty
  a_soft_irq: assert property (p_soft_irq)
    else $error("soft reset left interrupt up");
  property p_host_len;
    $fell(drive_se0) |-> s_cnt inside {[HOST_RST_CYC:HOST_RST_CYC+1]};
  endproperty
  a_host_len: assert property (p_host_len)
    else $error("host bus reset length wrong");
endmodule

bind usb_reset_wakeup_control usb_rst_asserts #(
  .IDLE_CYC(IDLE_CYC), .RESUME_CYC(RESUME_CYC),
  .HOST_RST_CYC(HOST_RST_CYC)
) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n),
  .hardware_reset_pin_n(hardware_reset_pin_n),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .bus_activity(bus_activity),
  .drive_k_state(drive_k_state), .drive_se0(drive_se0),
  .osc_run(osc_run), .pullup_on(pullup_on),
  .general_outputs(general_outputs), .irq_pending(irq_pending)
);

// [usb_far_end.sv]
// Behavioural USB bus partner: host line states, VBUS and traffic.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module usb_far_end (
  input  wire logic          drive_k_state,
  input  wire logic          drive_se0,
  output usb_rst_pkg::line_s line,
  output logic               bus_activity
);
  logic [1:0] mode;  // Host state: 0 J, 1 SE0, 2 K
  logic       vbus;  // VBUS level offered

  initial begin
    mode         = 2'h0;
    vbus         = 1'b0;
    bus_activity = 1'b0;
  end

  // Device drive wins over the host's idle state
  always_comb begin
    line.vbus = vbus;
    if (drive_se0) begin
      line.dp = 1'b0;
      line.dm = 1'b0;
    end else if (drive_k_state || mode == 2'h2) begin
      line.dp = 1'b0;  // K pulls D+ low for host wake
      line.dm = 1'b1;
    end else begin
      line.dp = (mode == 2'h0);
      line.dm = 1'b0;
    end
  end

  task automatic set_mode(input logic [1:0] m);
    mode <= m;
  endtask
  task automatic set_vbus(input logic v);
    vbus <= v;
  endtask
  task automatic set_act(input logic a);
    bus_activity <= a;
  endtask
endmodule

// [usb_reset_wakeup_control_tb.sv]
// Self-checking bench of the reset and wakeup block.
// Assumes short timing parameters and the partner model beside it.
`timescale 1ns/1ps
module usb_reset_wakeup_control_tb;
  localparam int IDLE = 40;
  localparam int RES  = 30;
  localparam int HRST = 25;
  localparam int SE0  = 20;
  localparam logic [3:0] EV = usb_rst_pkg::ADDR_USB_EVENT;
  localparam logic [3:0] EN = usb_rst_pkg::ADDR_USB_ENABLE;
  localparam logic [3:0] CT = usb_rst_pkg::ADDR_USB_CTRL;
  localparam logic [3:0] PC = usb_rst_pkg::ADDR_PIN_CTRL;

  logic                sys_clk;
  logic                arst_n;
  logic                hardware_reset_pin_n;
  logic [3:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  usb_rst_pkg::line_s  line;
  logic                bus_activity;
  logic                drive_k_state;
  logic                drive_se0;
  logic                osc_run;
  logic                pullup_on;
  logic [7:0]          general_outputs;
  logic                irq_pending;
  int                  n_mismatch = 0;
  int                  comparisons = 0;
  int                  cycles = 0;

  always #2 sys_clk = ~sys_clk;

  usb_reset_wakeup_control #(.IDLE_CYC(IDLE), .RESUME_CYC(RES),
    .HOST_RST_CYC(HRST), .OSC_CYC(20), .SE0_CYC(SE0)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .hardware_reset_pin_n(hardware_reset_pin_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dp(line.dp), .dm(line.dm), .vbus_sense_input(line.vbus),
    .bus_activity(bus_activity), .drive_k_state(drive_k_state),
    .drive_se0(drive_se0), .osc_run(osc_run), .pullup_on(pullup_on),
    .general_outputs(general_outputs), .irq_pending(irq_pending));

  usb_far_end i_far (.drive_k_state(drive_k_state),
    .drive_se0(drive_se0), .line(line), .bus_activity(bus_activity));

  // Hang guard, well above the planned run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One Avalon transfer; held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic rbit(input logic [3:0] a, input int b);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk({31'h0, q[b]}, 32'h1);
  endtask

  // Power-on values, unmapped read
  task automatic t_por;
    rreg(EV, 32'h380);
    rreg(CT, 32'h0);
    rreg(PC, 32'h0);
    rreg(EN, 32'h0);
    rreg(4'h2, 32'h0);
  endtask

  // Soft and pin chip reset: kept and cleared bits
  task automatic t_chip;
    wreg(EN, 32'h3ff);
    wreg(PC, 32'h1fff);
    wreg(CT, 32'ha6);
    wreg(CT, 32'ha7);
    cyc(3);
    rreg(CT, 32'h7);
    rreg(PC, 32'h1fff);
    rreg(EN, 32'h0);
    rreg(EV, 32'h380);
    chk({24'h0, general_outputs}, 32'hff);
    chk({31'h0, pullup_on}, 32'h1);
    wreg(CT, 32'h6);
    rreg(CT, 32'h6);
    wreg(EN, 32'h3ff);
    wreg(CT, 32'h86);
    hardware_reset_pin_n <= 1'b0;
    cyc(4);
    hardware_reset_pin_n <= 1'b1;
    rreg(EN, 32'h0);
    rreg(CT, 32'h6);
  endtask

  // VBUS edges raise separate flags
  task automatic t_vbus;
    wreg(EN, 32'h3ff);
    wreg(CT, 32'h86);
    wreg(EV, 32'h3ff);
    i_far.set_vbus(1'b1);
    cyc(4);
    rreg(EV, 32'h10);
    chk({31'h0, irq_pending}, 32'h1);
    i_far.set_vbus(1'b0);
    cyc(4);
    rreg(EV, 32'h30);
    wreg(EV, 32'h3ff);
    i_far.set_vbus(1'b1);
    cyc(4);
  endtask

  // Short SE0 runs ignored, long one is a bus reset
  task automatic t_bus_reset_request;
    repeat (2) begin
      i_far.set_mode(2'h1);
      cyc(SE0 - 4);
      i_far.set_mode(2'h0);
      cyc(2);
    end
    rreg(EV, 32'h10);
    i_far.set_mode(2'h1);
    cyc(SE0 + 4);
    rreg(EV, 32'h2);
    i_far.set_mode(2'h0);
    cyc(4);
    rreg(EV, 32'h6);
    rreg(EN, 32'h6);
    rreg(CT, 32'h86);
    rreg(PC, 32'h1fff);
  endtask

  // Host mode bus reset and its completion flag
  task automatic t_host;
    int n;
    wreg(EV, 32'h3ff);
    wreg(CT, 32'he6);
    n = 0;
    for (int i = 0; i < 50 && drive_se0 !== 1'b1; i++) @(negedge sys_clk);
    while (drive_se0 === 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(n >= HRST && n <= HRST + 1), 32'h1);
    cyc(2);
    rreg(EV, 32'h40);
    rreg(CT, 32'ha6);
    wreg(CT, 32'h86);
  endtask

  // Remote wakeup held off by traffic, then timed resume
  task automatic t_wake;
    int n;
    wreg(EV, 32'h3ff);
    i_far.set_act(1'b1);
    wreg(CT, 32'h96);
    n = 0;
    repeat (IDLE + 10) begin
      @(negedge sys_clk);
      if (drive_k_state !== 1'b0) n++;
    end
    chk(n, 0);
    @(posedge sys_clk);
    i_far.set_act(1'b0);
    n = 0;
    while (drive_k_state !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(n >= IDLE), 32'h1);
    n = 0;
    while (drive_k_state === 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(n >= RES && n <= RES + 1), 32'h1);
    cyc(2);
    rbit(EV, usb_rst_pkg::EV_RWU_DONE);
    wreg(CT, 32'h86);
  endtask

  // Power down stops the oscillator; D+ fall restarts it
  task automatic t_pdown;
    wreg(EV, 32'h3ff);
    wreg(CT, 32'he);
    cyc(4);
    chk({31'h0, osc_run}, 32'h0);
    i_far.set_mode(2'h2);
    cyc(5);
    chk({31'h0, osc_run}, 32'h1);
    cyc(30);
    i_far.set_mode(2'h0);
    rbit(EV, usb_rst_pkg::EV_OSC_OK);
    wreg(CT, 32'h6);
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n <= 1'b0;
    hardware_reset_pin_n <= 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    cyc(16);
    arst_n <= 1'b1;
    cyc(3);
    t_por();
    t_chip();
    t_vbus();
    t_bus_reset_request();
    t_host();
    t_wake();
    t_pdown();
    stop_test();
  end
endmodule
